//--- shared/smcf_pkg.sv
// smcf_pkg: constants, state codes and carrier types of the serial memory command front end.
// assumes: shared by the front end, its checker and its bench; no other dependencies.
package smcf_pkg;

    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
    localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] MEM_READ_CMD = 8'h03;
    localparam logic [7:0] MEM_WRITE_CMD = 8'h02;

    // ----------------------------------------------------------------
    // address and status layout
    // ----------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int ADDR_HI_W = 5;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] STATUS_CFG_MASK = 8'h8C;
    localparam int WRITE_LATCH_BIT = 1;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 13'h0001;

    // ----------------------------------------------------------------
    // buffering
    // ----------------------------------------------------------------
    localparam int WFIFO_DEPTH = 8;

    // ----------------------------------------------------------------
    // command state, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_OPCODE = 7'h01,
        ST_ADDR = 7'h02,
        ST_WDATA = 7'h04,
        ST_RDATA = 7'h08,
        ST_SREAD = 7'h10,
        ST_SWRITE = 7'h20,
        ST_IGNORE = 7'h40
    } smcf_cmd_state_type;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } smcf_wr_type;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
    } smcf_pins_type;

endpackage

//--- src/smcf_front_end.sv
// smcf_front_end: serial slave front end of a byte memory, with its write fifo.
// assumes: the serial pins come from another domain and are synchronised here;
// the memory side runs on ref_clk_i and answers rd_data_i for rd_addr_o within 2 cycles.
//
// Operation
// - memory holds 8192 bytes, each chosen by a 13-bit address.
// - two address bytes accepted, top three bits thrown away.
// - serial input sampled on rising clock edges after select goes low.
// - serial output changes on falling clock edges.
// - clock level at select fall picks mode 0 or 3.
// - all bytes travel most significant bit first both ways.
// - first byte after select falls is the opcode, steering what follows.
// - one opcode per select; master reselects for each operation.
// - while deselected, input ignored and output released.
// - undefined opcode ignores all input until next select, output released.
// - decode set latch, clear latch and status read opcodes.
// - decode status write, memory read and memory write; others invalid.
// - write latch cleared by reset, refusing writes until set.
// - set latch command sets the write latch.
// - write latch shows in status; status write data cannot set it.
// - latch cleared at select rise ending clear, status write or write.
// - after clear latch, writes blocked and status reads show the latch bit as zero.
// - one 8-bit status register, configurable and readable.
// - device only answers; it never starts a transfer.
// - each write is finished before a new transaction can arrive; here bytes queue in the 8-deep write fifo and are lost when it is full.
// - write latch is status bit 1: one permits writes.

// ----------------------------------------------------------------
// write fifo
// ----------------------------------------------------------------
module smcf_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    // plain synchronous fifo; reset empties it
    // count is one bit wider than the pointers, so full and empty
    // are told apart without a spare slot; the pointers wrap by compare,
    // so the depth need not be a power of two
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    // storage and pointers live in the one state record
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } smcf_fifo_state_type;

    smcf_fifo_state_type r;
    smcf_fifo_state_type next_r;
    logic push;
    logic pop;

    // honest full and empty flags
    assign in_ready_o = (r.count != FULL_COUNT);
    assign out_valid_o = (r.count != '0);
    assign out_data_o = r.mem[r.rd_ptr];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // pointer and storage update
    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wr_ptr] = in_data_i;
            next_r.wr_ptr = (r.wr_ptr == LAST_PTR) ? '0 : r.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_r.rd_ptr = (r.rd_ptr == LAST_PTR) ? '0 : r.rd_ptr + 1'b1;
        end
        // a push and a pop in one cycle leave the count alone
        if (push & ~pop) begin
            next_r.count = r.count + 1'b1;
        end else if (pop & ~push) begin
            next_r.count = r.count - 1'b1;
        end
    end

    // state register
    // reset empties the fifo; stored words are don't care
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r <= '0;
        end else if (clk_en_i) begin
            r <= next_r;
        end
    end
endmodule

// ----------------------------------------------------------------
// serial command front end
// ----------------------------------------------------------------
module smcf_front_end
    import smcf_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // serial pins
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    // memory write stream
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output smcf_wr_type wr_data_o,
    // memory read port
    output logic [ADDR_W-1:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    // status
    output logic write_latch_flag_o,
    output logic [7:0] status_o,
    output logic overrun_o
);
    // state record:
    // meta, sync - two-flop synchronisers of the serial pins
    // cs_n_d, sck_d - delayed copies for edge finding
    // state, bit_cnt, shift_in - command phase and receive side of the byte
    // addr_lo, is_write, addr - address phase and running address
    // armed - mode 3 guard, set at select fall in mode 0, otherwise at the first clock fall
    // out_cnt, shift_out - transmit side of the current byte
    // so, so_oe - registered serial output and its enable
    // write_latch_flag, clr_pend - write latch and its clear waiting for select rise
    // cfg - writable status bits
    // push, wdat - one-cycle hand-off into the write fifo
    // overrun - sticky flag for a byte lost to a full fifo
    typedef struct packed {
        smcf_pins_type meta;
        smcf_pins_type sync;
        logic cs_n_d;
        logic sck_d;
        smcf_cmd_state_type state;
        logic [2:0] bit_cnt;
        logic [7:0] shift_in;
        logic addr_lo;
        logic is_write;
        logic [ADDR_W-1:0] addr;
        logic armed;
        logic [2:0] out_cnt;
        logic [7:0] shift_out;
        logic so;
        logic so_oe;
        logic write_latch_flag;
        logic clr_pend;
        logic [7:0] cfg;
        logic push;
        smcf_wr_type wdat;
        logic overrun;
    } smcf_state_type;

    smcf_state_type r;
    smcf_state_type next_r;
    logic fifo_in_ready;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic [7:0] rx_byte;
    logic [7:0] status_val;
    logic [7:0] out_word;

    // edge detection on the second synchroniser stage only
    // the first stage may be unsettled, so nothing else reads it;
    // reset values match the idle pins, so no false edge follows reset
    assign cs_fall = r.cs_n_d & ~r.sync.cs_n;
    assign cs_rise = ~r.cs_n_d & r.sync.cs_n;
    assign sck_rise = ~r.sck_d & r.sync.sck;
    assign sck_fall = r.sck_d & ~r.sync.sck;
    assign rx_byte = {r.shift_in[6:0], r.sync.si};
    // fixed bits read zero, latch sits at its own bit
    // bits outside the writable mask are never stored
    assign status_val = (r.cfg & STATUS_CFG_MASK) | (8'(r.write_latch_flag) << WRITE_LATCH_BIT);

    // next-state logic
    // select fall opens a frame, select high closes it, and in between
    // clock falls drive the output and clock rises sample the input.
    // a fall and a rise never meet in one ref clock, because each
    // serial clock level lasts at least three ref clocks
    always_comb begin
        next_r = r;
        out_word = 8'h00;
        next_r.push = 1'b0;
        next_r.meta = '{cs_n: cs_n_i, sck: sck_i, si: si_i};
        next_r.sync = r.meta;
        next_r.cs_n_d = r.sync.cs_n;
        next_r.sck_d = r.sync.sck;
        if (cs_fall) begin
            // new frame: clock level picks the mode
            // clock high here means mode 3: the first rise waits for a fall
            next_r.armed = ~r.sync.sck;
            next_r.state = ST_OPCODE;
            next_r.bit_cnt = '0;
            next_r.out_cnt = '0;
        end else if (r.sync.cs_n) begin
            // deselected: drop partial byte, release output
            next_r.state = ST_OPCODE;
            next_r.bit_cnt = '0;
            next_r.so_oe = 1'b0;
            next_r.so = 1'b0;
            // a pending clear lands only once the frame is closed, so the
            // latch stays readable until the master lets go of select
            if (cs_rise & r.clr_pend) begin
                next_r.write_latch_flag = 1'b0;
            end
            if (cs_rise) begin
                next_r.clr_pend = 1'b0;
            end
        end else begin
            if (sck_fall) begin
                // mode 3 waits for the clock to go low first
                next_r.armed = 1'b1;
                // first bit of each byte loads a fresh word: memory data or status
                // out_cnt wraps after eight falls, so a status read repeats its byte
                if ((r.state == ST_RDATA) || (r.state == ST_SREAD)) begin
                    out_word = (r.out_cnt == '0) ?
                        ((r.state == ST_RDATA) ? rd_data_i : status_val) : r.shift_out;
                    next_r.so = out_word[7];
                    next_r.shift_out = {out_word[6:0], 1'b0};
                    next_r.so_oe = 1'b1;
                    next_r.out_cnt = r.out_cnt + 1'b1;
                    // next address is set a full bit time before its byte is driven
                    if ((r.out_cnt == BIT_LAST) && (r.state == ST_RDATA)) begin
                        next_r.addr = r.addr + ADDR_ONE;
                    end
                end
            end
            // in mode 0 armed is set at select fall, so the very first rise counts
            if (sck_rise & r.armed) begin
                // sample input, most significant bit first
                next_r.shift_in = rx_byte;
                next_r.bit_cnt = r.bit_cnt + 1'b1;
                if (r.bit_cnt == BIT_LAST) begin
                    case (r.state)
                        ST_OPCODE: begin
                            case (rx_byte)
                                SET_WRITE_LATCH_CMD: begin
                                    next_r.write_latch_flag = 1'b1;
                                    next_r.state = ST_IGNORE;
                                end
                                CLEAR_WRITE_LATCH_CMD: begin
                                    next_r.clr_pend = 1'b1;
                                    next_r.state = ST_IGNORE;
                                end
                                STATUS_READ_CMD: begin
                                    next_r.state = ST_SREAD;
                                end
                                STATUS_WRITE_CMD: begin
                                    next_r.clr_pend = 1'b1;
                                    next_r.state = ST_SWRITE;
                                end
                                MEM_READ_CMD: begin
                                    next_r.is_write = 1'b0;
                                    next_r.addr_lo = 1'b0;
                                    next_r.state = ST_ADDR;
                                end
                                MEM_WRITE_CMD: begin
                                    next_r.is_write = 1'b1;
                                    next_r.addr_lo = 1'b0;
                                    next_r.clr_pend = 1'b1;
                                    next_r.state = ST_ADDR;
                                end
                                default: begin
                                    next_r.state = ST_IGNORE;
                                end
                            endcase
                        end
                        ST_ADDR: begin
                            if (!r.addr_lo) begin
                                // top three address bits discarded
                                // the read port sees a half-built address here,
                                // harmless as nothing is shifted out yet
                                next_r.addr[ADDR_W-1:8] = rx_byte[ADDR_HI_W-1:0];
                                next_r.addr_lo = 1'b1;
                            end else begin
                                next_r.addr[7:0] = rx_byte;
                                next_r.state = r.is_write ? ST_WDATA : ST_RDATA;
                            end
                        end
                        ST_WDATA: begin
                            // byte handed on at once, no busy time
                            if (r.write_latch_flag) begin
                                if (fifo_in_ready) begin
                                    next_r.push = 1'b1;
                                    next_r.wdat = '{addr: r.addr, data: rx_byte};
                                end else begin
                                    next_r.overrun = 1'b1;
                                end
                                // a lost byte still moves the address on, so
                                // the bytes after it land where the master meant
                                next_r.addr = r.addr + ADDR_ONE;
                            end
                        end
                        ST_SWRITE: begin
                            // latch bit is not writable here
                            if (r.write_latch_flag) begin
                                next_r.cfg = rx_byte & STATUS_CFG_MASK;
                            end
                            next_r.state = ST_IGNORE;
                        end
                        ST_RDATA, ST_SREAD, ST_IGNORE: begin
                            next_r.state = r.state;
                        end
                        default: begin
                            next_r.state = ST_IGNORE;
                        end
                    endcase
                end
            end
        end
    end

    // state register; reset leaves latch cleared
    // clock enable low holds every field, synchronisers included
    // synchroniser reset values match a deselected bus with the clock low
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r <= '0;
            r.meta <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
            r.sync <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
            r.cs_n_d <= 1'b1;
            r.state <= ST_OPCODE;
            r.cfg <= STATUS_RESET;
            r.write_latch_flag <= 1'b0;
        end else if (clk_en_i) begin
            r <= next_r;
        end
    end

    // write stream buffer toward the memory
    // same clock and enable as the front end, so nothing crosses a domain
    smcf_fifo #(
        .WIDTH($bits(smcf_wr_type)),
        .DEPTH(WFIFO_DEPTH)
    ) u_wfifo (
        .clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .in_valid_i(r.push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(r.wdat),
        .out_valid_o(wr_valid_o),
        .out_ready_i(wr_ready_i),
        .out_data_o(wr_data_o)
    );

    // outputs from flip-flops, except status_o, decoded from cfg and the latch, and wr_valid_o and wr_data_o, decoded in the fifo
    // so_o rests at 0 and means nothing while so_oe_o is low
    assign so_o = r.so;
    assign so_oe_o = r.so_oe;
    assign rd_addr_o = r.addr;
    assign write_latch_flag_o = r.write_latch_flag;
    assign status_o = status_val;
    assign overrun_o = r.overrun;
endmodule

//--- tb/smcf_assertions.sv
// smcf_assertions: port-level checks of the serial command front end.
// assumes: bound to smcf_front_end; serial pins take 3 ref clocks to be seen.
module smcf_assertions
    import smcf_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // serial pins
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    // write stream and status
    input wire logic wr_valid_o,
    input wire logic wr_ready_i,
    input wire smcf_wr_type wr_data_o,
    input wire logic write_latch_flag_o,
    input wire logic [7:0] status_o,
    input wire logic overrun_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    latch_in_status_a: assert property (status_o[WRITE_LATCH_BIT] == write_latch_flag_o)
        else $error("status latch bit differs from latch");
    fixed_zero_bits_a: assert property ((status_o & 8'h71) == 8'h00)
        else $error("fixed status bits not zero");
    deselect_release_a: assert property (cs_n_i [*6] |-> !so_oe_o)
        else $error("output driven while deselected");
    drive_selected_a: assert property ($rose(so_oe_o) |-> !cs_n_i)
        else $error("output driven without select");
    so_on_fall_a: assert property ($changed(so_o) && so_oe_o && $past(so_oe_o) |-> !$past(sck_i))
        else $error("output changed outside clock low phase");
    latch_set_framed_a: assert property ($rose(write_latch_flag_o) |-> !$past(cs_n_i, 4))
        else $error("latch set outside a frame");
    latch_clear_end_a: assert property ($fell(write_latch_flag_o) |-> $past(cs_n_i, 3))
        else $error("latch cleared before select rose");
    write_needs_latch_a: assert property ($rose(wr_valid_o) |-> $past(write_latch_flag_o))
        else $error("write word without latch");
    word_holds_a: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_data_o))
        else $error("write word dropped while stalled");
    cover property (wr_valid_o && wr_ready_i);
    cover property ($rose(so_oe_o));
    cover property ($rose(overrun_o));
endmodule
bind smcf_front_end smcf_assertions i_smcf_assertions (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
    .so_o(so_o), .so_oe_o(so_oe_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
    .wr_data_o(wr_data_o), .write_latch_flag_o(write_latch_flag_o),
    .status_o(status_o), .overrun_o(overrun_o)
);

//--- tb/smcf_front_end_tb.sv
// smcf_front_end_tb: self-checking bench of the serial command front end.
// assumes: package, design, master model and checker compiled before it.
module smcf_front_end_tb
    import smcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, cs_n, sck, si, so, so_oe, latch, overrun;
    logic wr_valid, wr_ready = 1'b1, oe, stall = 1'b0, clk_en = 1'b1;
    logic [7:0] rd_data = 8'h00, status;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0] rx[$];
    smcf_wr_type wr_data, got_q[$], exp_q[$];
    int mismatches = 0, samples_checked = 0;
    always #20 clk = ~clk;
    smcf_front_end i_smcf_front_end (.ref_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(clk_en),
        .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe),
        .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_data_o(wr_data),
        .rd_addr_o(rd_addr), .rd_data_i(rd_data), .write_latch_flag_o(latch),
        .status_o(status), .overrun_o(overrun));
    smcf_master i_smcf_master (.clk_i(clk), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
        .so_i(so), .so_oe_i(so_oe));
    function automatic logic [7:0] memv(input logic [ADDR_W-1:0] a);
        return a[7:0] ^ {3'h0, a[12:8]};
    endfunction
    function automatic logic [7:0] stat_exp(input logic [7:0] cfg, input logic l);
        return (cfg & STATUS_CFG_MASK) | {6'h00, l, 1'b0};
    endfunction
    // memory model and write sink, stalling at random
    always @(posedge clk) begin
        rd_data <= memv(rd_addr);
        wr_ready <= !stall && ($urandom % 4 != 0);
        if (wr_valid && wr_ready) got_q.push_back(wr_data);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_w(input smcf_wr_type got, input smcf_wr_type exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic fr(input int m, input logic [7:0] tx[$]);
        i_smcf_master.run_frame(m[0], tx, 8 * tx.size(), rx, oe);
    endtask
    // wait for n popped words, then compare them in order
    task automatic drain(input int n);
        for (int k = 0; k < 400 && got_q.size() < n; k++) @(posedge clk);
        repeat (4) @(posedge clk);
        chk(8'(got_q.size()), 8'(n));
        if (got_q.size() < n) end_of_test();
        foreach (exp_q[i]) chk_w(got_q[i], exp_q[i]);
        got_q = {};
        exp_q = {};
    endtask
    initial begin
        #2ms;
        mismatches++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] a;
        logic [7:0] d;
        logic [7:0] tx[$];
        int n;
        void'($urandom(32'h9FC6));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk(status, STATUS_RESET);
        for (int m = 0; m < 2; m++) begin
            fr(m, {SET_WRITE_LATCH_CMD, CLEAR_WRITE_LATCH_CMD});
            chk({7'h00, latch}, 8'h01);
            fr(m, {STATUS_READ_CMD, 8'h00, 8'h00});
            chk(rx[1], stat_exp(8'h00, 1'b1));
            chk(rx[2], stat_exp(8'h00, 1'b1));
            fr(m, {CLEAR_WRITE_LATCH_CMD});
            fr(m, {STATUS_READ_CMD, 8'h00});
            chk(rx[1], stat_exp(8'h00, 1'b0));
        end
        d = 8'($urandom) & 8'hFD;
        fr(0, {SET_WRITE_LATCH_CMD});
        fr(1, {STATUS_WRITE_CMD, d});
        chk(status, stat_exp(d, 1'b0));
        fr(0, {STATUS_WRITE_CMD, ~d});
        chk(status, stat_exp(d, 1'b0));
        fr(0, {SET_WRITE_LATCH_CMD});
        fr(0, {STATUS_WRITE_CMD, 8'h00});
        chk(status, STATUS_RESET);
        // a frame sent while the clock enable is low must go unseen
        clk_en <= 1'b0;
        fr(1, {SET_WRITE_LATCH_CMD});
        clk_en <= 1'b1;
        chk({7'h00, latch}, 8'h00);
        for (int k = 0; k < 4; k++) begin
            d = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'h07 + 8'($urandom % 249);
            fr(k, {d, SET_WRITE_LATCH_CMD, STATUS_READ_CMD});
            chk({7'h00, latch | oe}, 8'h00);
        end
        i_smcf_master.run_frame(1'b0, {8'h00}, 5, rx, oe);
        fr(0, {SET_WRITE_LATCH_CMD});
        chk({7'h00, latch}, 8'h01);
        for (int k = 0; k < 3; k++) begin
            a = (k == 0) ? 16'hFFFF : 16'($urandom);
            n = (k == 2) ? 9 : 3;
            fr(k, {SET_WRITE_LATCH_CMD});
            stall <= (k == 2);
            tx = {MEM_WRITE_CMD, a[15:8], a[7:0]};
            for (int j = 0; j < n; j++) begin
                d = 8'($urandom);
                tx.push_back(d);
                if (j < 8) exp_q.push_back({13'(a[12:0] + j), d});
            end
            fr(k, tx);
            chk({7'h00, latch}, 8'h00);
            chk({7'h00, overrun}, {7'h00, k == 2});
            stall <= 1'b0;
            drain(exp_q.size());
        end
        fr(0, {MEM_WRITE_CMD, 8'h00, 8'h00, 8'h55});
        drain(0);
        a = 16'($urandom);
        fr(1, {MEM_READ_CMD, a[15:8], a[7:0], 8'h00, 8'h00});
        chk(rx[3], memv(a[12:0]));
        chk(rx[4], memv(a[12:0] + ADDR_ONE));
        end_of_test();
    end
endmodule

//--- tb/smcf_master.sv
// smcf_master: behavioural serial bus master for the front end.
// assumes: clk_i is the bench clock; the bench starts frames with run_frame.
module smcf_master (
    // clock
    input wire logic clk_i,
    // serial pins
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    input wire logic so_i,
    input wire logic so_oe_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end
    // released data line wanders every cycle while deselected
    always @(posedge clk_i) begin
        if (cs_n_o) si_o <= ~si_o;
    end
    // ------------------------------------------------------------
    // one frame, 8 clocks per serial bit; nbits may cut it short
    // ------------------------------------------------------------
    task automatic run_frame(input bit m3, input logic [7:0] tx[$], input int nbits,
                             output logic [7:0] rx[$], output logic oe_seen);
        logic [7:0] sh;
        logic last;
        rx = {};
        oe_seen = 1'b0;
        sh = 8'h00;
        last = 1'b0;
        @(posedge clk_i);
        sck_o <= m3;
        repeat (6) @(posedge clk_i);
        cs_n_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        for (int i = 0; i < nbits; i++) begin
            sck_o <= 1'b0;
            si_o <= tx[i / 8][7 - i % 8];
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            last = so_oe_i ? so_i : ~last;
            oe_seen = oe_seen | so_oe_i;
            sh = {sh[6:0], last};
            if (i % 8 == 7) rx.push_back(sh);
            repeat (2) @(posedge clk_i);
        end
        sck_o <= m3;
        repeat (8) @(posedge clk_i);
        cs_n_o <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask
endmodule
